// ==== smbcb_pkg.sv ====
// constants shared by the two ends of the clock buffer control link
// Summary of operation
// [R1] write starts: start, address d4, device acks
// [R2] host sends index byte, device acks
// [R3] block write: count byte follows, device acks
// [R4] data bytes fill N..N+X-1, each acked
// [R5] host ends block write with stop
// [R6] read: index write, repeated start, d5 acked
// [R7] device first returns the byte count
// [R8] then register contents from index N onward
// [R9] host acks each read byte except last
// [R10] host nacks last, stops; device releases data
// [R11] register 0 bit 7 picks pins or register
// [R12] bit 1 bandwidth, bit 0 loop active
// [R13] register 1 bits gate pairs 0,2,3,5
// [R14] reserved bits read-write, drive nothing
// [R15] index 5 read-back length, resets to 6
// [R16] index advances after every data byte
// [R17] unknown address left unacked, transaction ignored
package smbcb_pkg;
    localparam logic [7:0] ADDR_WRITE = 8'hd4;
    localparam logic [7:0] ADDR_READ = 8'hd5;
    localparam logic [7:0] IDX_LOOP_CONTROL = 8'h00;
    localparam logic [7:0] IDX_OUTPUT_GATE = 8'h01;
    localparam logic [7:0] IDX_FUNCTION_SPARE = 8'h02;
    localparam logic [7:0] IDX_READBACK_LENGTH = 8'h05;
    localparam logic [7:0] LOOP_CONTROL_RESET = 8'h83;
    localparam logic [7:0] OUTPUT_GATE_RESET = 8'h2d;
    localparam logic [7:0] FUNCTION_SPARE_RESET = 8'h00;
    localparam logic [7:0] READBACK_LENGTH_RESET = 8'h06;
    localparam int LOOP_SOURCE_BIT = 7;
    localparam int LOOP_BANDWIDTH_BIT = 1;
    localparam int LOOP_ENABLE_BIT = 0;
    localparam int PAIR0_BIT = 0;
    localparam int PAIR2_BIT = 2;
    localparam int PAIR3_BIT = 3;
    localparam int PAIR5_BIT = 5;
    // host register map, byte addresses on apb
    localparam logic [11:0] HOST_CMD_OFFSET = 12'h000;
    localparam logic [11:0] HOST_WDATA_OFFSET = 12'h004;
    localparam logic [11:0] HOST_STATUS_OFFSET = 12'h008;
    localparam logic [11:0] HOST_RDATA_OFFSET = 12'h00c;
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CMD_COUNT_LSB = 8;
    localparam int CMD_INDEX_LSB = 16;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_NACK_BIT = 1;
    localparam int STATUS_COUNT_LSB = 8;
    localparam logic [2:0] HOST_MAX_BYTES = 3'h4;
    // timing in mclk cycles
    localparam int SCL_QUARTER_CYCLES = 16;
    localparam int LINK_CLK_HALF_CYCLES = 2;
endpackage

// ==== smbcb_link_if.sv ====
// two-wire link between host controller and clock buffer target
`timescale 1ns/1ps
interface smbcb_link_if;
    logic link_clk;
    logic scl_out_h;
    logic scl_oe_h;
    logic sda_out_h;
    logic sda_oe_h;
    logic sda_out_d;
    logic sda_oe_d;
    logic scl;
    logic sda;

    // open-drain wires with pull-up
    assign scl = ~(scl_oe_h & ~scl_out_h);
    assign sda = ~((sda_oe_h & ~sda_out_h) | (sda_oe_d & ~sda_out_d));

    modport host (output link_clk, output scl_out_h, output scl_oe_h, output sda_out_h,
        output sda_oe_h, input scl, input sda);
    modport device (input link_clk, input scl, input sda, output sda_out_d, output sda_oe_d);
endinterface

// ==== smbcb_target.sv ====
// clock buffer control target: two-wire slave and control register bank
//
// Chosen here: the control registers are reached only over the two-wire link; APB sits on the host.
`timescale 1ns/1ps
module smbcb_target (
    smbcb_link_if.device link,
    input wire logic rst_in,
    input wire logic pin_bandwidth_in,
    input wire logic pin_loop_enable_in,
    output logic loop_bandwidth_select_out,
    output logic loop_active_out,
    output logic [5:0] output_pair_gate_out
);
    typedef enum logic [2:0] {T_IDLE, T_RX, T_RX_ACK, T_TX, T_TX_ACK, T_IGNORE} smbcb_tstate_type;
    typedef enum logic [1:0] {S_ADDR, S_INDEX, S_COUNT, S_DATA} smbcb_stage_type;

    typedef struct packed {
        smbcb_tstate_type state;
        smbcb_stage_type stage;
        logic read_mode;
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        logic bw_s1;
        logic bw_s2;
        logic en_s1;
        logic en_s2;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        logic [7:0] index;
        logic [7:0] remain;
        logic sda_drive;
        logic [7:0] loop_control;
        logic [7:0] output_gate;
        logic [7:0] function_spare;
        logic [7:0] readback_length;
        logic bw_out;
        logic active_out;
        logic [5:0] gate_out;
    } smbcb_tgt_type;

    smbcb_tgt_type st_reg;
    smbcb_tgt_type st_next;

    function automatic logic [7:0] reg_read(input smbcb_tgt_type s, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            smbcb_pkg::IDX_LOOP_CONTROL: v = s.loop_control;
            smbcb_pkg::IDX_OUTPUT_GATE: v = s.output_gate;
            smbcb_pkg::IDX_FUNCTION_SPARE: v = s.function_spare;
            smbcb_pkg::IDX_READBACK_LENGTH: v = s.readback_length;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic start_cond;
        logic stop_cond;
        logic [7:0] b;
        logic [7:0] tx;
        scl = st_reg.scl_s2;
        sda = st_reg.sda_s2;
        rise = scl & ~st_reg.scl_d;
        fall = ~scl & st_reg.scl_d;
        start_cond = scl & st_reg.scl_d & st_reg.sda_d & ~sda;
        stop_cond = scl & st_reg.scl_d & ~st_reg.sda_d & sda;
        b = st_reg.shreg;
        tx = 8'h00;
        st_next = st_reg;
        st_next.scl_s1 = link.scl;
        st_next.scl_s2 = st_reg.scl_s1;
        st_next.scl_d = st_reg.scl_s2;
        st_next.sda_s1 = link.sda;
        st_next.sda_s2 = st_reg.sda_s1;
        st_next.sda_d = st_reg.sda_s2;
        st_next.bw_s1 = pin_bandwidth_in;
        st_next.bw_s2 = st_reg.bw_s1;
        st_next.en_s1 = pin_loop_enable_in;
        st_next.en_s2 = st_reg.en_s1;

        if (start_cond) begin
            st_next.state = T_RX;
            st_next.stage = S_ADDR;
            st_next.read_mode = 1'b0;
            st_next.bitcnt = 4'h0;
            st_next.sda_drive = 1'b0;
        end else if (stop_cond) begin
            st_next.state = T_IDLE;
            st_next.sda_drive = 1'b0;
        end else begin
            unique case (st_reg.state)
                T_IDLE, T_IGNORE: begin
                    st_next.sda_drive = 1'b0;
                end
                T_RX: begin
                    if (rise) begin
                        st_next.shreg = {st_reg.shreg[6:0], sda};
                        st_next.bitcnt = st_reg.bitcnt + 4'h1;
                    end else if (fall && st_reg.bitcnt == 4'h8) begin
                        st_next.bitcnt = 4'h0;
                        st_next.state = T_RX_ACK;
                        st_next.sda_drive = 1'b1;
                        unique case (st_reg.stage)
                            S_ADDR: begin
                                if (b == smbcb_pkg::ADDR_WRITE) begin
                                    st_next.stage = S_INDEX; // R1
                                end else if (b == smbcb_pkg::ADDR_READ) begin
                                    st_next.read_mode = 1'b1; // R6
                                end else begin
                                    st_next.state = T_IGNORE; // R17
                                    st_next.sda_drive = 1'b0;
                                end
                            end
                            S_INDEX: begin
                                st_next.index = b; // R2
                                st_next.stage = S_COUNT;
                            end
                            S_COUNT: begin
                                st_next.remain = b; // R3
                                st_next.stage = S_DATA;
                            end
                            S_DATA: begin
                                if (st_reg.remain != 8'h00) begin
                                    unique case (st_reg.index) // R4
                                        smbcb_pkg::IDX_LOOP_CONTROL: st_next.loop_control = b;
                                        smbcb_pkg::IDX_OUTPUT_GATE: st_next.output_gate = b;
                                        smbcb_pkg::IDX_FUNCTION_SPARE: st_next.function_spare = b;
                                        smbcb_pkg::IDX_READBACK_LENGTH: st_next.readback_length = b; // R15
                                        default: st_next.remain = st_reg.remain - 8'h01;
                                    endcase
                                    st_next.remain = st_reg.remain - 8'h01;
                                    st_next.index = st_reg.index + 8'h01; // R16
                                end else begin
                                    st_next.state = T_IGNORE;
                                    st_next.sda_drive = 1'b0;
                                end
                            end
                        endcase
                    end
                end
                T_RX_ACK: begin
                    if (fall) begin
                        if (st_reg.read_mode) begin
                            st_next.shreg = st_reg.readback_length; // R7
                            st_next.sda_drive = ~st_reg.readback_length[7];
                            st_next.state = T_TX;
                        end else begin
                            st_next.sda_drive = 1'b0;
                            st_next.state = T_RX;
                        end
                    end
                end
                T_TX: begin
                    if (rise) begin
                        st_next.bitcnt = st_reg.bitcnt + 4'h1;
                    end else if (fall) begin
                        st_next.shreg = {st_reg.shreg[6:0], 1'b0};
                        if (st_reg.bitcnt == 4'h8) begin
                            st_next.sda_drive = 1'b0;
                            st_next.state = T_TX_ACK;
                        end else begin
                            st_next.sda_drive = ~st_reg.shreg[6];
                        end
                    end
                end
                T_TX_ACK: begin
                    if (rise) begin
                        if (sda) begin
                            st_next.state = T_IGNORE; // R10
                        end else begin
                            st_next.bitcnt = 4'h9; // R9
                        end
                    end else if (fall && st_reg.bitcnt == 4'h9) begin
                        tx = reg_read(st_reg, st_reg.index);
                        st_next.shreg = tx; // R8
                        st_next.sda_drive = ~tx[7];
                        st_next.index = st_reg.index + 8'h01; // R16
                        st_next.bitcnt = 4'h0;
                        st_next.state = T_TX;
                    end
                end
                default: st_next.state = T_IDLE;
            endcase
        end

        // pins or register pick the loop controls
        if (st_reg.loop_control[smbcb_pkg::LOOP_SOURCE_BIT]) begin // R11
            st_next.bw_out = st_reg.bw_s2;
            st_next.active_out = st_reg.en_s2;
        end else begin
            st_next.bw_out = st_reg.loop_control[smbcb_pkg::LOOP_BANDWIDTH_BIT]; // R12
            st_next.active_out = st_reg.loop_control[smbcb_pkg::LOOP_ENABLE_BIT];
        end
        // pairs 1 and 4 have no register gate; reserved bits drive nothing
        st_next.gate_out = {st_reg.output_gate[smbcb_pkg::PAIR5_BIT], 1'b1, // R13 R14
            st_reg.output_gate[smbcb_pkg::PAIR3_BIT], st_reg.output_gate[smbcb_pkg::PAIR2_BIT],
            1'b1, st_reg.output_gate[smbcb_pkg::PAIR0_BIT]};

        if (rst_in) begin
            st_next = '0;
            st_next.state = T_IDLE;
            st_next.stage = S_ADDR;
            st_next.scl_s1 = 1'b1;
            st_next.scl_s2 = 1'b1;
            st_next.scl_d = 1'b1;
            st_next.sda_s1 = 1'b1;
            st_next.sda_s2 = 1'b1;
            st_next.sda_d = 1'b1;
            st_next.loop_control = smbcb_pkg::LOOP_CONTROL_RESET;
            st_next.output_gate = smbcb_pkg::OUTPUT_GATE_RESET;
            st_next.function_spare = smbcb_pkg::FUNCTION_SPARE_RESET;
            st_next.readback_length = smbcb_pkg::READBACK_LENGTH_RESET; // R15
            st_next.bw_out = 1'b0;
            st_next.active_out = 1'b0;
            st_next.gate_out = 6'h3f;
        end
    end

    always_ff @(posedge link.link_clk) begin
        st_reg <= st_next;
    end

    assign link.sda_out_d = 1'b0;
    assign link.sda_oe_d = st_reg.sda_drive; // R10
    assign loop_bandwidth_select_out = st_reg.bw_out;
    assign loop_active_out = st_reg.active_out;
    assign output_pair_gate_out = st_reg.gate_out;
endmodule

// ==== smbcb_host.sv ====
// host controller: apb registers drive block writes and reads on the link
`timescale 1ns/1ps
module smbcb_host (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    smbcb_link_if.host link
);
    typedef enum logic [2:0] {H_IDLE, H_START, H_WBYTE, H_RBYTE, H_STOP} smbcb_hstate_type;

    typedef struct packed {
        smbcb_hstate_type state;
        logic [3:0] step;
        logic [1:0] ph;
        logic [4:0] qcnt;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic ack_seen;
        logic scl_low;
        logic sda_low;
        logic sda_s1;
        logic sda_s2;
        logic [1:0] div;
        logic lclk;
        logic busy;
        logic nack_err;
        logic rd;
        logic [2:0] cnt;
        logic [7:0] idx;
        logic [3:0][7:0] wdata;
        logic [3:0][7:0] rdata;
        logic [7:0] rcount;
        logic [31:0] prdata;
    } smbcb_host_type;

    smbcb_host_type st_reg;
    smbcb_host_type st_next;

    // element at a sequence step: kind and byte to send
    function automatic smbcb_hstate_type step_kind(input smbcb_host_type s, input logic [3:0] k,
            output logic [7:0] b);
        smbcb_hstate_type r;
        logic [3:0] c;
        c = {1'b0, s.cnt};
        b = 8'h00;
        r = H_STOP;
        if (k == 4'h0 || (s.rd && k == 4'h3)) begin
            r = H_START; // R6
        end else if (k == 4'h1) begin
            r = H_WBYTE;
            b = smbcb_pkg::ADDR_WRITE; // R1
        end else if (k == 4'h2) begin
            r = H_WBYTE;
            b = s.idx; // R2
        end else if (!s.rd && k == 4'h3) begin
            r = H_WBYTE;
            b = {5'h00, s.cnt}; // R3
        end else if (!s.rd && k <= 4'h3 + c) begin
            r = H_WBYTE;
            b = s.wdata[2'(k - 4'h4)]; // R4
        end else if (s.rd && k == 4'h4) begin
            r = H_WBYTE;
            b = smbcb_pkg::ADDR_READ;
        end else if (s.rd && k <= 4'h5 + c) begin
            r = H_RBYTE;
        end
        return r; // R5
    endfunction

    always_comb begin
        logic acc;
        logic launch;
        logic tick;
        logic [7:0] nb;
        logic [3:0] last_rd;
        acc = psel_in & penable_in;
        launch = 1'b0;
        nb = 8'h00;
        last_rd = 4'h5 + {1'b0, st_reg.cnt};
        tick = st_reg.qcnt == 5'(smbcb_pkg::SCL_QUARTER_CYCLES - 1);
        st_next = st_reg;
        st_next.sda_s1 = link.sda;
        st_next.sda_s2 = st_reg.sda_s1;
        st_next.div = st_reg.div + 2'h1;
        if (st_reg.div == 2'(smbcb_pkg::LINK_CLK_HALF_CYCLES - 1)) begin
            st_next.div = 2'h0;
            st_next.lclk = ~st_reg.lclk;
        end

        if (psel_in && !penable_in) begin
            unique case (paddr_in)
                smbcb_pkg::HOST_CMD_OFFSET: st_next.prdata = {8'h00, st_reg.idx, 5'h00,
                    st_reg.cnt, 6'h00, st_reg.rd, 1'b0};
                smbcb_pkg::HOST_WDATA_OFFSET: st_next.prdata = st_reg.wdata;
                smbcb_pkg::HOST_STATUS_OFFSET: st_next.prdata = {16'h0000, st_reg.rcount,
                    6'h00, st_reg.nack_err, st_reg.busy};
                smbcb_pkg::HOST_RDATA_OFFSET: st_next.prdata = st_reg.rdata;
                default: st_next.prdata = 32'h00000000;
            endcase
        end
        if (acc && pwrite_in && !st_reg.busy) begin
            if (paddr_in == smbcb_pkg::HOST_WDATA_OFFSET) begin
                st_next.wdata = pwdata_in;
            end else if (paddr_in == smbcb_pkg::HOST_CMD_OFFSET &&
                    pwdata_in[smbcb_pkg::CMD_GO_BIT]) begin
                st_next.rd = pwdata_in[smbcb_pkg::CMD_READ_BIT];
                st_next.cnt = pwdata_in[smbcb_pkg::CMD_COUNT_LSB +: 3];
                if (pwdata_in[smbcb_pkg::CMD_COUNT_LSB +: 3] > smbcb_pkg::HOST_MAX_BYTES) begin
                    st_next.cnt = smbcb_pkg::HOST_MAX_BYTES;
                end
                st_next.idx = pwdata_in[smbcb_pkg::CMD_INDEX_LSB +: 8];
                st_next.busy = 1'b1;
                st_next.nack_err = 1'b0;
                st_next.step = 4'h0;
                launch = 1'b1;
            end
        end

        if (st_reg.busy) begin
            st_next.qcnt = tick ? 5'h00 : st_reg.qcnt + 5'h01;
            if (tick) begin
                st_next.ph = st_reg.ph + 2'h1;
                unique case (st_reg.state)
                    H_START: begin
                        if (st_reg.ph == 2'h0) st_next.scl_low = 1'b0;
                        if (st_reg.ph == 2'h1) st_next.sda_low = 1'b1;
                        if (st_reg.ph == 2'h3) begin
                            st_next.step = st_reg.step + 4'h1;
                            launch = 1'b1;
                        end
                    end
                    H_STOP: begin
                        if (st_reg.ph == 2'h0) st_next.sda_low = 1'b1;
                        if (st_reg.ph == 2'h1) st_next.scl_low = 1'b0;
                        if (st_reg.ph == 2'h2) st_next.sda_low = 1'b0;
                        if (st_reg.ph == 2'h3) begin
                            st_next.busy = 1'b0;
                            st_next.state = H_IDLE;
                        end
                    end
                    H_WBYTE, H_RBYTE: begin
                        if (st_reg.ph == 2'h0) begin
                            if (st_reg.bitcnt != 4'h8) begin
                                st_next.sda_low = (st_reg.state == H_WBYTE) & ~st_reg.shreg[7];
                            end else begin
                                st_next.sda_low = (st_reg.state == H_RBYTE) &&
                                    (st_reg.step != last_rd); // R9 R10
                            end
                        end
                        if (st_reg.ph == 2'h1) st_next.scl_low = 1'b0;
                        if (st_reg.ph == 2'h2) begin
                            if (st_reg.bitcnt == 4'h8) begin
                                st_next.ack_seen = ~st_reg.sda_s2;
                            end else if (st_reg.state == H_RBYTE) begin
                                st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_s2};
                            end
                        end
                        if (st_reg.ph == 2'h3) begin
                            st_next.scl_low = 1'b1;
                            if (st_reg.bitcnt != 4'h8) begin
                                st_next.bitcnt = st_reg.bitcnt + 4'h1;
                                if (st_reg.state == H_WBYTE) begin
                                    st_next.shreg = {st_reg.shreg[6:0], 1'b0};
                                end
                            end else begin
                                launch = 1'b1;
                                st_next.step = st_reg.step + 4'h1;
                                if (st_reg.state == H_WBYTE && !st_reg.ack_seen) begin
                                    st_next.nack_err = 1'b1;
                                    st_next.step = 4'hf;
                                end
                                if (st_reg.state == H_RBYTE && st_reg.step == 4'h5) begin
                                    st_next.rcount = st_reg.shreg; // R7
                                end else if (st_reg.state == H_RBYTE) begin
                                    st_next.rdata[2'(st_reg.step - 4'h6)] = st_reg.shreg;
                                end
                            end
                        end
                    end
                    default: st_next.state = H_IDLE;
                endcase
            end
        end

        if (launch) begin
            st_next.state = step_kind(st_next, st_next.step, nb);
            st_next.shreg = nb;
            st_next.ph = 2'h0;
            st_next.qcnt = 5'h00;
            st_next.bitcnt = 4'h0;
            st_next.scl_low = 1'b1;
            if (st_next.state == H_START) st_next.sda_low = 1'b0;
        end

        if (rst_in) begin
            st_next = '0;
            st_next.state = H_IDLE;
        end
    end

    always_ff @(posedge mclk_in) begin
        st_reg <= st_next;
    end

    assign prdata_out = st_reg.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && paddr_in != smbcb_pkg::HOST_CMD_OFFSET &&
        paddr_in != smbcb_pkg::HOST_WDATA_OFFSET && paddr_in != smbcb_pkg::HOST_STATUS_OFFSET &&
        paddr_in != smbcb_pkg::HOST_RDATA_OFFSET;
    assign link.link_clk = st_reg.lclk;
    assign link.scl_out_h = 1'b0;
    assign link.scl_oe_h = st_reg.scl_low;
    assign link.sda_out_h = 1'b0;
    assign link.sda_oe_h = st_reg.sda_low;
endmodule

// ==== smbcb_link_properties.sv ====
// link timing checks for the clock buffer control link
`timescale 1ns/1ps
module smbcb_link_properties (
    input wire logic link_clk,
    input wire logic rst_in,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe_h,
    input wire logic sda_oe_d
);
    default clocking @(posedge link_clk); endclocking
    default disable iff (rst_in);
    property p_ack_low; $rose(sda_oe_d) |-> !scl && !$past(scl, 2); endproperty
    a_ack_low: assert property (p_ack_low) else $error("drive began near scl high");
    property p_rel_low; $fell(sda_oe_d) |-> !scl; endproperty
    a_rel_low: assert property (p_rel_low) else $error("release with scl high");
    property p_hold; $rose(scl) |=> $stable(sda_oe_d) [*6]; endproperty
    a_hold: assert property (p_hold) else $error("sda moved with scl high");
    property p_stop; $rose(sda) && scl && $past(scl) |-> !sda_oe_d [*8]; endproperty
    a_stop: assert property (p_stop) else $error("sda held after stop");
    property p_start; $fell(sda) && scl && $past(scl) |-> !sda_oe_d; endproperty
    a_start: assert property (p_start) else $error("sda held at start");
    property p_bound; $rose(sda_oe_d) |-> ##[1:300] !sda_oe_d; endproperty
    a_bound: assert property (p_bound) else $error("sda held too long");
    property p_low; $rose(scl_oe_h) |-> ##[4:40] !scl_oe_h; endproperty
    a_low: assert property (p_low) else $error("scl low too long");
    property p_high; $fell(scl_oe_h) |-> scl [*4]; endproperty
    a_high: assert property (p_high) else $error("scl high too short");
endmodule

// ==== test_smbus_clock_buffer_control.sv ====
// bench: apb-driven block transfers between host and target
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
$display("wrong value at %0t: %h %h", $time, a, b); end end
module test_smbus_clock_buffer_control;
    logic mclk_in = 1'b0;
    logic rst = 1'b1;
    logic rst_t = 1'b1;
    logic [11:0] pa = 12'h000;
    logic ps = 1'b0;
    logic pe = 1'b0;
    logic pw = 1'b0;
    logic [31:0] pd = 32'h0;
    logic [31:0] prd;
    logic prdy;
    logic perr;
    logic sl;
    logic pbw = 1'b0;
    logic pen = 1'b1;
    logic bw;
    logic act;
    logic [5:0] gate;
    logic [31:0] rd;
    logic [31:0] st;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    smbcb_link_if lb();
    smbcb_host i_smbcb_host (.mclk_in(mclk_in), .rst_in(rst), .paddr_in(pa), .psel_in(ps),
        .penable_in(pe), .pwrite_in(pw), .pwdata_in(pd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .link(lb));
    smbcb_target i_smbcb_target (.link(lb), .rst_in(rst_t), .pin_bandwidth_in(pbw),
        .pin_loop_enable_in(pen), .loop_bandwidth_select_out(bw), .loop_active_out(act),
        .output_pair_gate_out(gate));
    smbcb_link_properties i_props (.link_clk(lb.link_clk), .rst_in(rst_t), .scl(lb.scl),
        .sda(lb.sda), .scl_oe_h(lb.scl_oe_h), .sda_oe_d(lb.sda_oe_d));
    always #4 mclk_in = ~mclk_in;
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        pa <= a;
        pw <= w;
        pd <= d;
        ps <= 1'b1;
        @(posedge mclk_in);
        pe <= 1'b1;
        do @(posedge mclk_in); while (prdy !== 1'b1);
        rd = prd;
        sl = perr;
        ps <= 1'b0;
        pe <= 1'b0;
        @(posedge mclk_in);
    endtask
    // one block transfer: data word, command, wait for idle, fetch read data
    task automatic xfer(input logic r, input logic [7:0] idx, input logic [2:0] n,
        input logic [31:0] d);
        apb(1'b1, 12'h004, d);
        apb(1'b1, 12'h000, {8'h00, idx, 5'h00, n, 6'h00, r, 1'b1});
        rd = 32'h1;
        while (rd[0] !== 1'b0) apb(1'b0, 12'h008, 32'h0);
        st = rd;
        repeat (16) @(posedge mclk_in);
        apb(1'b0, 12'h00c, 32'h0);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge mclk_in);
        rst <= 1'b0;
        repeat (8) @(posedge mclk_in);
        rst_t <= 1'b0;
        // pin synchroniser plus output register need three link edges
        repeat (16) @(posedge mclk_in);
        `CHK({bw, act, gate}, 8'h7f)
        // count above the host limit is clamped to four bytes
        xfer(1'b1, 8'h00, 3'h7, 32'h0);
        `CHK({st[15:8], st[1:0]}, 10'h018)
        `CHK(rd, 32'h00002d83)
        xfer(1'b0, 8'h00, 3'h3, 32'h00a51202);
        `CHK(st[1], 1'b0)
        `CHK({bw, act, gate}, 8'h92)
        xfer(1'b1, 8'h00, 3'h3, 32'h0);
        `CHK(rd[23:0], 24'ha51202)
        xfer(1'b0, 8'h05, 3'h1, 32'h02);
        xfer(1'b1, 8'h01, 3'h2, 32'h0);
        `CHK({st[15:8], rd[15:0]}, 24'h02a512)
        pbw <= 1'b1;
        pen <= 1'b0;
        xfer(1'b0, 8'h00, 3'h1, 32'h80);
        `CHK({bw, act, gate}, 8'h92)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({sl, rd}, 33'h100000000)
        test_done();
    end
endmodule
